// file: rtl/clks_sequencer.sv
`timescale 1ns/1ps
// Behaviour
// - Noncacheable write block runs the no-allocate flow
// - Line select points at free buffer line
// - Write request raises tag enable, CPU enable
// - I/O write octawords stored at selected line
// - Next cycle: data enable, tag qualifier, select
// - Drop enables, then request acknowledge via command
// - Command acknowledges cycle, tag qualifier dropped
// - No acknowledge request yet: hold data qualifier
// - Load-locked: read block plus lock, probe
// - Read block hit handled as unlocked hit
// - Dirty hit data staged through merge buffer
// - Locked request: cache and tag enables
// - Set lock, load address; clear command wins
// - Dirty hit asserts address enable; clean hit, miss from memory
// - Load merge buffer, bit four low first
// - Wait, drive two octawords with read acks
// - Acknowledge cycle, restore drivers, accept next
// - Clear command forces store-conditional to fail
module clks_sequencer
   import clks_pkg::*;
#(
   parameter int LINES = BUF_LINES
) (
   input  wire logic                                 ref_clk,
   input  wire logic                                 nrst,
   input  wire logic [2:0]                           cycle_request,
   input  wire logic [LOCK_ADDR_MSB:LOCK_ADDR_LSB]   system_address,
   input  wire logic [3:0]                           cycle_write_mask,
   input  wire logic                                 address_is_io,
   input  wire logic                                 tag_hit,
   input  wire logic                                 tag_dirty,
   input  wire logic [DATA_W-1:0]                    system_data_bus_in,
   input  wire logic                                 pci_ack_ready,
   input  wire logic                                 clear_reservation_request,
   input  wire logic                                 unload_read_en,
   input  wire logic [1:0]                           unload_read_line,
   input  wire logic                                 unload_read_half,
   input  wire logic                                 unload_done,
   input  wire logic [1:0]                           unload_done_line,
   output      logic                                 early_output_enable,
   output      logic                                 tag_ram_output_enable,
   output      logic                                 cache_ram_output_enable,
   output      logic                                 cpu_data_output_enable_n,
   output      logic                                 system_data_output_enable,
   output      logic                                 tag_output_enable_qualifier,
   output      logic                                 data_output_enable_qualifier,
   output      logic                                 second_octaword_select,
   output      logic                                 data_address_enable,
   output      logic                                 cache_data_address_4,
   output      logic [2:0]                           cycle_acknowledge,
   output      logic [2:0]                           data_read_acknowledge,
   output      logic [2:0]                           io_command,
   output      logic [1:0]                           buffer_line_select,
   output      logic                                 unload_ready,
   output      logic [1:0]                           unload_line,
   output      logic [DATA_W-1:0]                    internal_unload_bus,
   output      logic [DATA_W-1:0]                    system_data_bus_out,
   output      logic                                 system_data_bus_oe,
   output      logic                                 memory_read_request,
   output      logic                                 lock_flag,
   output      logic [LOCK_ADDR_MSB:LOCK_ADDR_LSB]   lock_address
);

   if (LINES < 2 || LINES > 4) begin : g_check
      $error("clks_sequencer: LINES must be 2 to 4 for a two-bit line select");
   end

   // ---------------------------------------------------------------
   // State
   // ---------------------------------------------------------------
   typedef struct packed {
      clks_state_t                        state;
      logic                               is_io;
      logic                               is_ll;
      logic                               early_oe;
      logic                               tag_oe;
      logic                               cache_oe;
      logic                               cpu_doe_n;
      logic                               sys_doe;
      logic                               tag_qual;
      logic                               data_qual;
      logic                               dwsel;
      logic                               data_addr_en;
      logic                               addr4;
      logic                               drive_oe;
      logic [2:0]                         cack;
      logic [2:0]                         drack;
      logic [2:0]                         io_cmd;
      logic [1:0]                         line_sel;
      logic [LINES-1:0]                   line_busy;
      logic                               unload_rdy;
      logic [1:0]                         unload_ln;
      logic                               mem_req;
      logic                               lock;
      logic [LOCK_ADDR_MSB:LOCK_ADDR_LSB] lock_addr;
   } clks_seq_t;

   clks_seq_t r_reg;
   clks_seq_t r_next;

   clks_buf_if buf_bus ();

   clks_octaword_store #(
      .SLOTS (LINES + 1)
   ) u_store (
      .ref_clk (ref_clk),
      .nrst    (nrst),
      .bus     (buf_bus.store)
   );

   // ---------------------------------------------------------------
   // Free line search
   // ---------------------------------------------------------------
   function automatic logic [1:0] clks_first_free(input logic [LINES-1:0] busy);
      logic [1:0] idx;
      idx = 2'h0;
      for (int i = LINES - 1; i >= 0; i--) begin
         if (!busy[i]) begin
            idx = i[1:0];
         end
      end
      return idx;
   endfunction : clks_first_free

   logic any_free;
   assign any_free = ~&r_reg.line_busy;

   // ---------------------------------------------------------------
   // Next state
   // ---------------------------------------------------------------
   always_comb begin
      r_next            = r_reg;
      r_next.cack       = CACK_IDLE;
      r_next.drack      = DRACK_IDLE;
      r_next.unload_rdy = 1'b0;
      r_next.mem_req    = 1'b0;
      r_next.io_cmd     = clear_reservation_request ? IO_COMMAND_CLEAR_RES : IO_COMMAND_IDLE;
      buf_bus.wr_en     = 1'b0;
      buf_bus.wr_slot   = {1'b0, r_reg.line_sel};
      buf_bus.wr_half   = 1'b0;
      buf_bus.wr_data   = system_data_bus_in;
      buf_bus.rd_en     = unload_read_en;
      buf_bus.rd_slot   = {1'b0, unload_read_line};
      buf_bus.rd_half   = unload_read_half;

      if (unload_done) begin
         r_next.line_busy[unload_done_line] = 1'b0;
      end
      // Clear beats set: the reservation stays off while the command is sent
      if (r_reg.io_cmd == IO_COMMAND_CLEAR_RES) begin
         r_next.lock = 1'b0;
      end

      case (r_reg.state)
         ST_IDLE: begin
            // Held for the whole of bus ownership
            r_next.line_sel = clks_first_free(r_next.line_busy);
            if (cycle_request == CREQ_WRITE_BLOCK) begin
               // Noncacheable and no-allocate share this flow
               r_next.is_io     = address_is_io;
               r_next.tag_oe    = 1'b1;
               r_next.cpu_doe_n = 1'b0;
               r_next.state     = ST_WB_FIRST;
            end else if (cycle_request == CREQ_LOAD_LOCKED ||
                         cycle_request == CREQ_READ_BLOCK) begin
               // Plain read block takes the same path without the lock
               r_next.is_ll    = (cycle_request == CREQ_LOAD_LOCKED);
               r_next.cache_oe = 1'b1;
               r_next.tag_oe   = 1'b1;
               r_next.state    = ST_LL_PROBE;
            end
         end
         ST_WB_FIRST: begin
            buf_bus.wr_en        = r_reg.is_io;
            buf_bus.wr_half      = 1'b0;
            r_next.sys_doe       = 1'b1;
            r_next.tag_qual      = 1'b1;
            r_next.dwsel         = 1'b1;
            r_next.state         = ST_WB_SECOND;
         end
         ST_WB_SECOND: begin
            buf_bus.wr_en   = r_reg.is_io;
            buf_bus.wr_half = 1'b1;
            r_next.sys_doe  = 1'b0;
            r_next.dwsel    = 1'b0;
            r_next.early_oe = 1'b0;
            if (r_reg.is_io) begin
               if (pci_ack_ready && any_free) begin
                  r_next.io_cmd = IO_COMMAND_ACK_REQ;
               end
               r_next.state = ST_WB_IO_WAIT;
            end else begin
               r_next.cack      = CACK_OK;
               r_next.tag_qual  = 1'b0;
               r_next.tag_oe    = 1'b0;
               r_next.cpu_doe_n = RST_CPU_DOE_N;
               r_next.early_oe  = RST_EARLY_OE;
               r_next.state     = ST_IDLE;
            end
         end
         ST_WB_IO_WAIT: begin
            if (r_reg.io_cmd == IO_COMMAND_ACK_REQ) begin
               r_next.cack                        = CACK_OK;
               r_next.tag_qual                    = 1'b0;
               r_next.data_qual                   = 1'b0;
               r_next.tag_oe                      = 1'b0;
               r_next.cpu_doe_n                   = RST_CPU_DOE_N;
               r_next.early_oe                    = RST_EARLY_OE;
               r_next.line_busy[r_reg.line_sel]   = 1'b1;
               r_next.unload_rdy                  = 1'b1;
               r_next.unload_ln                   = r_reg.line_sel;
               r_next.state                       = ST_IDLE;
            end else begin
               // Keeps the data bus from floating while the PCI side stalls
               r_next.data_qual = 1'b1;
               if (pci_ack_ready && any_free) begin
                  r_next.io_cmd = IO_COMMAND_ACK_REQ;
               end
            end
         end
         ST_LL_PROBE: begin
            if (r_reg.is_ll && r_reg.io_cmd != IO_COMMAND_CLEAR_RES) begin
               r_next.lock      = 1'b1;
               r_next.lock_addr = system_address;
            end
            if (tag_hit && tag_dirty) begin
               r_next.data_addr_en = 1'b1;
               r_next.addr4        = 1'b0;
               r_next.early_oe     = 1'b0;
               r_next.state        = ST_LL_LOAD_LO;
            end else begin
               // Clean hit and miss are served from memory by the read path
               r_next.mem_req  = 1'b1;
               r_next.cache_oe = 1'b0;
               r_next.tag_oe   = 1'b0;
               r_next.state    = ST_IDLE;
            end
         end
         ST_LL_LOAD_LO: begin
            // Never straight to the CPU: avoids the address-to-data race
            buf_bus.wr_en   = 1'b1;
            buf_bus.wr_slot = MERGE_SLOT;
            buf_bus.wr_half = 1'b0;
            r_next.addr4    = 1'b1;
            r_next.state    = ST_LL_LOAD_HI;
         end
         ST_LL_LOAD_HI: begin
            buf_bus.wr_en   = 1'b1;
            buf_bus.wr_slot = MERGE_SLOT;
            buf_bus.wr_half = 1'b1;
            r_next.addr4    = 1'b0;
            r_next.cache_oe = 1'b0;
            r_next.state    = ST_LL_TRISTATE;
         end
         ST_LL_TRISTATE: begin
            // Cache RAMs release the bus; merge read wins over unload here
            buf_bus.rd_en   = 1'b1;
            buf_bus.rd_slot = MERGE_SLOT;
            buf_bus.rd_half = 1'b0;
            r_next.drive_oe = 1'b1;
            r_next.drack    = DRACK_OK;
            r_next.state    = ST_LL_DRIVE_LO;
         end
         ST_LL_DRIVE_LO: begin
            buf_bus.rd_en   = 1'b1;
            buf_bus.rd_slot = MERGE_SLOT;
            buf_bus.rd_half = 1'b1;
            r_next.drack    = DRACK_OK;
            r_next.state    = ST_LL_DRIVE_HI;
         end
         ST_LL_DRIVE_HI: begin
            r_next.cack         = CACK_OK;
            r_next.drive_oe     = 1'b0;
            r_next.tag_oe       = 1'b0;
            r_next.data_addr_en = 1'b0;
            r_next.early_oe     = RST_EARLY_OE;
            r_next.state        = ST_IDLE;
         end
         default: begin
            r_next.state = ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge ref_clk) begin
      if (!nrst) begin
         r_reg           <= '0;
         r_reg.state     <= ST_IDLE;
         r_reg.early_oe  <= RST_EARLY_OE;
         r_reg.cpu_doe_n <= RST_CPU_DOE_N;
         r_reg.lock      <= RST_LOCK;
      end else begin
         r_reg <= r_next;
      end
   end

   // ---------------------------------------------------------------
   // Outputs
   // ---------------------------------------------------------------
   assign early_output_enable          = r_reg.early_oe;
   assign tag_ram_output_enable        = r_reg.tag_oe;
   assign cache_ram_output_enable      = r_reg.cache_oe;
   assign cpu_data_output_enable_n     = r_reg.cpu_doe_n;
   assign system_data_output_enable    = r_reg.sys_doe;
   assign tag_output_enable_qualifier  = r_reg.tag_qual;
   assign data_output_enable_qualifier = r_reg.data_qual;
   assign second_octaword_select       = r_reg.dwsel;
   assign data_address_enable          = r_reg.data_addr_en;
   assign cache_data_address_4         = r_reg.addr4;
   assign cycle_acknowledge            = r_reg.cack;
   assign data_read_acknowledge        = r_reg.drack;
   assign io_command                   = r_reg.io_cmd;
   assign buffer_line_select           = r_reg.line_sel;
   assign unload_ready                 = r_reg.unload_rdy;
   assign unload_line                  = r_reg.unload_ln;
   assign internal_unload_bus          = buf_bus.rd_data;
   assign system_data_bus_out          = buf_bus.rd_data;
   assign system_data_bus_oe           = r_reg.drive_oe;
   assign memory_read_request          = r_reg.mem_req;
   assign lock_flag                    = r_reg.lock;
   assign lock_address                 = r_reg.lock_addr;

   // ---------------------------------------------------------------
   // Checks
   // ---------------------------------------------------------------
   a_wb_request_oe:
   assert property (@(posedge ref_clk) disable iff (!nrst)
      (r_reg.state == ST_IDLE && cycle_request == CREQ_WRITE_BLOCK)
      |=> (tag_ram_output_enable && !cpu_data_output_enable_n)
         ##1 (system_data_output_enable && second_octaword_select))
      else $error("write block enables missing");

   a_wb_second_select:
   assert property (@(posedge ref_clk) disable iff (!nrst)
      $rose(second_octaword_select)
      |-> (system_data_output_enable && tag_output_enable_qualifier
           && $past(!cpu_data_output_enable_n)))
      else $error("second select without qualifiers");

   a_select_one_cycle:
   assert property (@(posedge ref_clk) disable iff (!nrst)
      second_octaword_select |=> (!second_octaword_select && !system_data_output_enable))
      else $error("select held too long");

   a_io_ack_follow:
   assert property (@(posedge ref_clk) disable iff (!nrst)
      (r_reg.state == ST_WB_IO_WAIT && io_command == IO_COMMAND_ACK_REQ)
      |=> (cycle_acknowledge == CACK_OK && !tag_output_enable_qualifier
           && !data_output_enable_qualifier))
      else $error("io acknowledge not given");

   a_io_wait_qual:
   assert property (@(posedge ref_clk) disable iff (!nrst)
      (r_reg.state == ST_WB_IO_WAIT && io_command != IO_COMMAND_ACK_REQ)
      |=> data_output_enable_qualifier)
      else $error("data bus left floating");

   a_lock_clear_cmd:
   assert property (@(posedge ref_clk) disable iff (!nrst)
      io_command == IO_COMMAND_CLEAR_RES |=> !lock_flag)
      else $error("lock survived clear command");

   a_ll_request_oe:
   assert property (@(posedge ref_clk) disable iff (!nrst)
      (r_reg.state == ST_IDLE && cycle_request == CREQ_LOAD_LOCKED)
      |=> (cache_ram_output_enable && tag_ram_output_enable))
      else $error("locked load enables missing");

   a_ll_return_pair:
   assert property (@(posedge ref_clk) disable iff (!nrst)
      $rose(data_address_enable)
      |-> ##3 (data_read_acknowledge == DRACK_OK && system_data_bus_oe)
          ##1 (data_read_acknowledge == DRACK_OK)
          ##1 (cycle_acknowledge == CACK_OK && !system_data_bus_oe))
      else $error("merge return sequence wrong");

   a_load_first_half:
   assert property (@(posedge ref_clk) disable iff (!nrst)
      r_reg.state == ST_LL_LOAD_LO
      |-> (!cache_data_address_4 && !early_output_enable) ##1 cache_data_address_4)
      else $error("merge load address order wrong");

   a_line_sel_stable:
   assert property (@(posedge ref_clk) disable iff (!nrst)
      (r_reg.state != ST_IDLE) |=> $stable(buffer_line_select))
      else $error("line select moved during ownership");

endmodule : clks_sequencer

// file: rtl/clks_pkg.sv
package clks_pkg;

   // ---------------------------------------------------------------
   // Bus encodings
   // ---------------------------------------------------------------
   localparam logic [2:0] CREQ_READ_BLOCK  = 3'h4;
   localparam logic [2:0] CREQ_WRITE_BLOCK = 3'h5;
   localparam logic [2:0] CREQ_LOAD_LOCKED = 3'h6;
   localparam logic [2:0] CACK_IDLE        = 3'h0;
   localparam logic [2:0] CACK_OK          = 3'h4;
   localparam logic [2:0] DRACK_IDLE       = 3'h0;
   localparam logic [2:0] DRACK_OK         = 3'h5;
   localparam logic [2:0] IO_COMMAND_IDLE       = 3'h0;
   localparam logic [2:0] IO_COMMAND_ACK_REQ    = 3'h1;
   localparam logic [2:0] IO_COMMAND_CLEAR_RES  = 3'h2;

   // ---------------------------------------------------------------
   // Buffer layout and field positions
   // ---------------------------------------------------------------
   localparam int         DATA_W        = 128;
   localparam int         BUF_LINES     = 4;
   localparam int         SLOT_W        = 3;
   localparam logic [2:0] MERGE_SLOT    = 3'h4;
   localparam int         LOCK_ADDR_MSB = 33;
   localparam int         LOCK_ADDR_LSB = 5;
   localparam int         WRAP_MASK_BIT = 1;

   // ---------------------------------------------------------------
   // Reset values
   // ---------------------------------------------------------------
   localparam logic       RST_EARLY_OE  = 1'b1;
   localparam logic       RST_CPU_DOE_N = 1'b1;
   localparam logic       RST_LOCK      = 1'b0;

   typedef enum logic [3:0] {
      ST_IDLE, ST_WB_FIRST, ST_WB_SECOND, ST_WB_IO_WAIT, ST_LL_PROBE, ST_LL_LOAD_LO,
      ST_LL_LOAD_HI, ST_LL_TRISTATE, ST_LL_DRIVE_LO, ST_LL_DRIVE_HI
   } clks_state_t;

endpackage : clks_pkg

// file: rtl/clks_buf_if.sv
`timescale 1ns/1ps
interface clks_buf_if;
   import clks_pkg::*;
   logic                wr_en;
   logic [SLOT_W-1:0]   wr_slot;
   logic                wr_half;
   logic [DATA_W-1:0]   wr_data;
   logic                rd_en;
   logic [SLOT_W-1:0]   rd_slot;
   logic                rd_half;
   logic [DATA_W-1:0]   rd_data;
   modport ctrl  (output wr_en, wr_slot, wr_half, wr_data, rd_en, rd_slot, rd_half,
                  input rd_data);
   modport store (input wr_en, wr_slot, wr_half, wr_data, rd_en, rd_slot, rd_half,
                  output rd_data);
endinterface : clks_buf_if

// file: rtl/clks_octaword_store.sv
`timescale 1ns/1ps
module clks_octaword_store
   import clks_pkg::*;
#(
   parameter int SLOTS = BUF_LINES + 1
) (
   input  wire logic  ref_clk,
   input  wire logic  nrst,
   clks_buf_if.store  bus
);
   // ---------------------------------------------------------------
   // Storage: line slots plus the merge slot, two octawords each
   // ---------------------------------------------------------------
   typedef struct packed {
      logic [DATA_W-1:0] rd_data;
   } clks_store_t;

   clks_store_t       st_reg;
   clks_store_t       st_next;
   logic [DATA_W-1:0] mem [SLOTS*2];

   if (SLOTS < 2 || SLOTS > (1 << (SLOT_W - 1)) + 1) begin : g_check
      $error("clks_octaword_store: SLOTS out of range");
   end

   always_comb begin
      st_next = st_reg;
      if (bus.rd_en) begin
         st_next.rd_data = mem[{bus.rd_slot, bus.rd_half}];
      end
   end

   // Array left out of reset: contents are only read after being written
   always_ff @(posedge ref_clk) begin
      if (bus.wr_en) begin
         mem[{bus.wr_slot, bus.wr_half}] <= bus.wr_data;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!nrst) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end

   assign bus.rd_data = st_reg.rd_data;

endmodule : clks_octaword_store

// file: dv/clks_cpu_model.sv
`timescale 1ns/1ps
module clks_cpu_model
   import clks_pkg::*;
#(
   parameter logic [DATA_W-1:0] W1 = '0,
   parameter logic [DATA_W-1:0] W2 = '0,
   parameter logic [DATA_W-1:0] C0 = '0,
   parameter logic [DATA_W-1:0] C1 = '0
) (
   input  wire logic              ref_clk,
   input  wire logic              doe_n,
   input  wire logic              dwsel,
   input  wire logic              cache_oe,
   input  wire logic              addr4,
   output      logic [DATA_W-1:0] bus
);
   // Released bus shows a moving pattern, never the last value
   logic [DATA_W-1:0] junk = '0;
   always_ff @(posedge ref_clk) begin
      junk <= {junk[DATA_W-2:0], ~junk[DATA_W-1]};
   end
   always_comb begin
      if (dwsel) bus = W2;
      else if (!doe_n) bus = W1;
      else if (cache_oe) bus = addr4 ? C1 : C0;
      else bus = junk;
   end
endmodule : clks_cpu_model

// file: dv/cpu_io_write_and_locked_load_sequencer_bench.sv
`timescale 1ns/1ps
`define CHK(a, e) begin n_compared++; if ((a) !== (e)) begin err_total++; \
   $display("[FAIL] %0t got %h", $time, (a)); end end
module cpu_io_write_and_locked_load_sequencer_bench;
   import clks_pkg::*;
   localparam logic [DATA_W-1:0] W1 = {4{32'h1111_0001}}, W2 = {4{32'h2222_0002}};
   localparam logic [DATA_W-1:0] C0 = {4{32'hc0c0_0003}}, C1 = {4{32'hc1c1_0004}};
   logic ref_clk = 1'b0, nrst = 1'b0, address_is_io = 1'b0, tag_hit = 1'b0, tag_dirty = 1'b0;
   logic pci_ack_ready = 1'b0, clear_reservation_request = 1'b0, unload_read_en = 1'b0;
   logic unload_read_half = 1'b0, unload_done = 1'b0;
   logic [2:0] cycle_request = 3'h0, cycle_acknowledge, data_read_acknowledge, io_command;
   logic [3:0] cycle_write_mask = 4'h0;
   logic [1:0] unload_read_line = 2'h0, unload_done_line = 2'h0, ln, buffer_line_select, unload_line;
   logic [LOCK_ADDR_MSB:LOCK_ADDR_LSB] system_address = '0, lock_address;
   logic [DATA_W-1:0] system_data_bus_in, internal_unload_bus, system_data_bus_out;
   logic early_output_enable, tag_ram_output_enable, cache_ram_output_enable, unload_ready;
   logic cpu_data_output_enable_n, system_data_output_enable, tag_output_enable_qualifier;
   logic data_output_enable_qualifier, second_octaword_select, data_address_enable;
   logic cache_data_address_4, system_data_bus_oe, memory_read_request, lock_flag;
   int err_total = 0;
   int n_compared = 0;
   always #12.5 ref_clk = ~ref_clk;
   clks_sequencer DUT (.ref_clk, .nrst, .cycle_request, .system_address, .cycle_write_mask,
      .address_is_io, .tag_hit, .tag_dirty, .system_data_bus_in, .pci_ack_ready,
      .clear_reservation_request, .unload_read_en, .unload_read_line, .unload_read_half,
      .unload_done, .unload_done_line, .early_output_enable, .tag_ram_output_enable,
      .cache_ram_output_enable, .cpu_data_output_enable_n, .system_data_output_enable,
      .tag_output_enable_qualifier, .data_output_enable_qualifier, .second_octaword_select,
      .data_address_enable, .cache_data_address_4, .cycle_acknowledge, .data_read_acknowledge,
      .io_command, .buffer_line_select, .unload_ready, .unload_line, .internal_unload_bus,
      .system_data_bus_out, .system_data_bus_oe, .memory_read_request, .lock_flag, .lock_address);
   clks_cpu_model #(.W1(W1), .W2(W2), .C0(C0), .C1(C1)) CPU (.ref_clk,
      .doe_n(cpu_data_output_enable_n), .dwsel(second_octaword_select),
      .cache_oe(cache_ram_output_enable), .addr4(cache_data_address_4), .bus(system_data_bus_in));
   // ---------------------------------------------------------------
   // Scenarios
   // ---------------------------------------------------------------
   task automatic step(input logic [2:0] r);
      @(posedge ref_clk) cycle_request <= r;
      #1;
   endtask : step
   task automatic t_write(input logic io);
      @(posedge ref_clk) address_is_io <= io;
      step(CREQ_WRITE_BLOCK);
      ln = buffer_line_select;
      step(3'h0);
      `CHK({tag_ram_output_enable, cpu_data_output_enable_n}, 2'h2)
      step(3'h0);
      `CHK({system_data_output_enable, second_octaword_select, tag_output_enable_qualifier}, 3'h7)
      step(3'h0);
      `CHK({system_data_output_enable, second_octaword_select}, 2'h0)
      if (!io) begin
         `CHK(cycle_acknowledge, CACK_OK)
      end else begin
         // PCI side late on purpose: qualifier must hold the bus
         `CHK(io_command, IO_COMMAND_IDLE)
         step(3'h0);
         `CHK(data_output_enable_qualifier, 1'b1)
         @(posedge ref_clk) pci_ack_ready <= 1'b1;
         for (int i = 0; i < 6 && io_command !== IO_COMMAND_ACK_REQ; i++) step(3'h0);
         `CHK(io_command, IO_COMMAND_ACK_REQ)
         step(3'h0);
         `CHK({cycle_acknowledge, tag_output_enable_qualifier}, {CACK_OK, 1'b0})
         `CHK({unload_ready, unload_line}, {1'b1, ln})
         @(posedge ref_clk) {pci_ack_ready, unload_read_en, unload_read_line} <= {2'b01, ln};
         step(3'h0);
         `CHK(internal_unload_bus, W1)
         `CHK(buffer_line_select == ln, 1'b0)
         @(posedge ref_clk) unload_read_half <= 1'b1;
         step(3'h0);
         `CHK(internal_unload_bus, W2)
         @(posedge ref_clk) {unload_read_en, unload_done, unload_done_line} <= {2'b01, ln};
         @(posedge ref_clk) {unload_done, unload_read_half} <= 2'b00;
      end
      $display("write block done, io=%0d", io);
   endtask : t_write
   task automatic t_lock(input logic [2:0] r, input logic lk);
      @(posedge ref_clk) {system_address, cycle_write_mask, tag_hit, tag_dirty} <= {29'h0abc_def1, 4'h2, 2'h3};
      step(r);
      step(3'h0);
      `CHK({cache_ram_output_enable, tag_ram_output_enable}, 2'h3)
      step(3'h0);
      `CHK({data_address_enable, cache_data_address_4, early_output_enable}, 3'h4)
      `CHK({lock_flag, memory_read_request}, {lk, 1'b0})
      if (lk) `CHK(lock_address, 29'h0abc_def1)
      for (int i = 0; i < 9 && data_read_acknowledge !== DRACK_OK; i++) step(3'h0);
      `CHK({data_read_acknowledge, system_data_bus_oe, system_data_bus_out}, {DRACK_OK, 1'b1, C0})
      step(3'h0);
      `CHK({data_read_acknowledge, system_data_bus_out}, {DRACK_OK, C1})
      step(3'h0);
      `CHK({cycle_acknowledge, system_data_bus_oe, early_output_enable}, {CACK_OK, 2'h1})
      $display("locked or hit load done, request=%0d", r);
   endtask : t_lock
   task automatic t_clear;
      @(posedge ref_clk) clear_reservation_request <= 1'b1;
      step(3'h0);
      step(3'h0);
      `CHK({io_command, lock_flag}, {IO_COMMAND_CLEAR_RES, 1'b0})
      $display("reservation cleared");
   endtask : t_clear
   task automatic t_clean;
      @(posedge ref_clk) {tag_hit, tag_dirty} <= 2'h2;
      step(CREQ_READ_BLOCK);
      step(3'h0);
      step(3'h0);
      `CHK({memory_read_request, cache_ram_output_enable, data_address_enable}, 3'h4)
      step(3'h0);
      `CHK(memory_read_request, 1'b0)
      $display("clean hit handed to memory");
   endtask : t_clean
   task automatic test_done;
      $display("compared %0d, mismatches %0d", n_compared, err_total);
      if (err_total == 0 && n_compared > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask : test_done
   initial begin
      repeat (20) @(posedge ref_clk);
      nrst <= 1'b1;
      #1;
      `CHK({early_output_enable, cpu_data_output_enable_n, lock_flag}, 3'h6)
      t_write(1'b0);
      t_write(1'b1);
      t_lock(CREQ_LOAD_LOCKED, 1'b1);
      t_clear();
      t_lock(CREQ_READ_BLOCK, 1'b0);
      t_lock(CREQ_LOAD_LOCKED, 1'b0);
      t_clean();
      test_done();
   end
   // Whole run needs well under 400 cycles
   initial begin
      #100000;
      err_total++;
      test_done();
   end
endmodule : cpu_io_write_and_locked_load_sequencer_bench
